// >>> rtl/acm_top.sv
/*
 analog compare monitor: difference comparator with hysteresis/window and a band monitor
 around a captured reference. assumes samples, parameters and enable are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: scale both comparator inputs by gain, offset
// R2: clamp gain, offset, thresholds to ranges
// R3: decimal places ignored in comparisons
// R4: difference is scaled first minus second
// R5: hysteresis: high above on, low below off
// R6: window: high when on <= diff < off
// R7: sources deliver 0 to 1000 samples
// R8: rising enable captures reference sample
// R9: monitor scales reference and live value
// R10: output high if enabled and outside band
// R11: output low inside band or enable low
// R12: clamp band parameter to range
// R13: monitor decimal places only for display
// R14: hysteresis holds output between thresholds
// R15: reset clears outputs, reference; wide arithmetic
module acm_top
	import acm_pkg::*;
(
	// clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	// comparator
	input  wire logic signed [SAMPLE_W-1:0] i_first_analog_input,
	input  wire logic signed [SAMPLE_W-1:0] i_second_analog_input,
	input  wire logic signed [GAIN_W-1:0]   i_cmp_gain,
	input  wire logic signed [PARAM_W-1:0]  i_cmp_offset,
	input  wire logic signed [PARAM_W-1:0]  i_cmp_on,
	input  wire logic signed [PARAM_W-1:0]  i_cmp_off,
	input  wire logic [DIGITS_W-1:0]        i_cmp_digits,
	output logic                            o_cmp_out,
	// monitor
	input  wire logic                       i_mon_enable,
	input  wire logic signed [SAMPLE_W-1:0] i_mon_input,
	input  wire logic signed [GAIN_W-1:0]   i_mon_gain,
	input  wire logic signed [PARAM_W-1:0]  i_mon_offset,
	input  wire logic signed [PARAM_W-1:0]  i_mon_band,
	input  wire logic [DIGITS_W-1:0]        i_mon_digits,
	output logic                            o_mon_out,
	output logic signed [SAMPLE_W-1:0]      o_mon_reference
);
	logic signed [SCALED_W-1:0] x_scaled;
	logic signed [SCALED_W-1:0] y_scaled;
	logic signed [SCALED_W-1:0] live_scaled;
	logic signed [SCALED_W-1:0] ref_scaled;
	logic signed [DIFF_W-1:0]   diff;
	logic signed [DIFF_W-1:0]   on_c;
	logic signed [DIFF_W-1:0]   off_c;
	logic signed [DIFF_W-1:0]   band_c;
	logic signed [DIFF_W-1:0]   low_lim;
	logic signed [DIFF_W-1:0]   high_lim;
	acm_mode_type               mode;
	logic                       cmp_d, cmp_q;
	logic                       mon_d, mon_q;
	logic                       en_d, en_q;
	logic signed [SAMPLE_W-1:0] ref_d, ref_q;
	logic                       outside;
	logic                       ref_for_scale_sel;
	logic signed [SAMPLE_W-1:0] ref_for_scale;

	acm_scale u_scale_x (
		.i_value  (i_first_analog_input),
		.i_gain   (i_cmp_gain),
		.i_offset (i_cmp_offset),
		.o_scaled (x_scaled)
	);
	acm_scale u_scale_y (
		.i_value  (i_second_analog_input),
		.i_gain   (i_cmp_gain),
		.i_offset (i_cmp_offset),
		.o_scaled (y_scaled)
	);
	acm_scale u_scale_live (
		.i_value  (i_mon_input),
		.i_gain   (i_mon_gain),
		.i_offset (i_mon_offset),
		.o_scaled (live_scaled)
	);
	acm_scale u_scale_ref (
		.i_value  (ref_for_scale),
		.i_gain   (i_mon_gain),
		.i_offset (i_mon_offset),
		.o_scaled (ref_scaled)
	);

	function automatic logic signed [DIFF_W-1:0] clamp_t(input logic signed [PARAM_W-1:0] v);
		logic signed [DIFF_W-1:0] r;
		r = DIFF_W'(v);
		if (v > THRESH_MAX)
			r = DIFF_W'(THRESH_MAX);
		else if (v < -THRESH_MAX)
			r = -DIFF_W'(THRESH_MAX);
		return r;
	endfunction

	// comparator: digits inputs deliberately unused in arithmetic
	always_comb begin
		diff = DIFF_W'(x_scaled) - DIFF_W'(y_scaled); // R4 R15
		on_c = clamp_t(i_cmp_on); // R2
		off_c = clamp_t(i_cmp_off); // R2
		mode = (on_c >= off_c) ? ACM_MODE_HYST : ACM_MODE_WINDOW; // R3
		cmp_d = cmp_q; // R14
		case (mode)
			ACM_MODE_HYST: begin
				if (diff > on_c)
					cmp_d = 1'b1; // R5
				else if (diff < off_c)
					cmp_d = 1'b0; // R5
			end
			ACM_MODE_WINDOW: begin
				cmp_d = (diff >= on_c) && (diff < off_c); // R6
			end
			default: begin
				cmp_d = OUT_RESET;
			end
		endcase
	end

	// reference source: a rising enable feeds the live sample straight to the scaler,
	// so the capture cycle already compares against the new reference
	always_comb begin
		ref_for_scale_sel = i_mon_enable && !en_q; // R8
		ref_for_scale = ref_for_scale_sel ? i_mon_input : ref_q;
	end

	// monitor: capture on enable edge, band test on scaled values
	always_comb begin
		en_d = i_mon_enable;
		ref_d = ref_for_scale; // R8
		band_c = clamp_t(i_mon_band); // R12 R13
		if (band_c < 0)
			band_c = -band_c;
		low_lim = DIFF_W'(ref_scaled) - band_c; // R9
		high_lim = DIFF_W'(ref_scaled) + band_c;
		outside = (DIFF_W'(live_scaled) < low_lim) || (DIFF_W'(live_scaled) > high_lim);
		mon_d = i_mon_enable && outside; // R10 R11
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cmp_q <= OUT_RESET; // R15
			mon_q <= OUT_RESET;
			en_q <= 1'b0;
			ref_q <= REF_RESET;
		end else begin
			cmp_q <= cmp_d;
			mon_q <= mon_d;
			en_q <= en_d;
			ref_q <= ref_d;
		end
	end

	assign o_cmp_out = cmp_q;
	assign o_mon_out = mon_q;
	assign o_mon_reference = ref_q;

	property p_hyst_set;
		@(posedge i_clk) disable iff (i_rst)
		(mode == ACM_MODE_HYST && diff > on_c) |=> o_cmp_out;
	endproperty
	a_hyst_set: assert property (p_hyst_set) else $error("hysteresis did not set"); // R5

	property p_hyst_clr;
		@(posedge i_clk) disable iff (i_rst)
		(mode == ACM_MODE_HYST && diff < off_c) |=> !o_cmp_out;
	endproperty
	a_hyst_clr: assert property (p_hyst_clr) else $error("hysteresis did not clear"); // R5

	property p_hold;
		@(posedge i_clk) disable iff (i_rst)
		(mode == ACM_MODE_HYST && diff <= on_c && diff >= off_c) |=> (o_cmp_out == $past(o_cmp_out));
	endproperty
	a_hold: assert property (p_hold) else $error("hysteresis did not hold"); // R14

	property p_window;
		@(posedge i_clk) disable iff (i_rst)
		(mode == ACM_MODE_WINDOW) |=> (o_cmp_out == $past(diff >= on_c && diff < off_c));
	endproperty
	a_window: assert property (p_window) else $error("window output wrong"); // R6

	property p_capture;
		@(posedge i_clk) disable iff (i_rst)
		$rose(i_mon_enable) |=> (o_mon_reference == $past(i_mon_input));
	endproperty
	a_capture: assert property (p_capture) else $error("reference not captured"); // R8

	property p_ref_stable;
		@(posedge i_clk) disable iff (i_rst)
		!(i_mon_enable && !en_q) |=> $stable(o_mon_reference);
	endproperty
	a_ref_stable: assert property (p_ref_stable) else $error("reference changed without edge"); // R8

	property p_mon_low;
		@(posedge i_clk) disable iff (i_rst)
		!i_mon_enable |=> !o_mon_out;
	endproperty
	a_mon_low: assert property (p_mon_low) else $error("monitor high while disabled"); // R11

	property p_mon_out;
		@(posedge i_clk) disable iff (i_rst)
		(i_mon_enable && outside) |=> o_mon_out;
	endproperty
	a_mon_out: assert property (p_mon_out) else $error("monitor missed excursion"); // R10

	property p_capture_quiet;
		@(posedge i_clk) disable iff (i_rst)
		(i_mon_enable && !en_q) |=> !o_mon_out;
	endproperty
	a_capture_quiet: assert property (p_capture_quiet) else $error("monitor high on capture"); // R11

	property p_mon_in;
		@(posedge i_clk) disable iff (i_rst)
		(i_mon_enable && !outside) |=> !o_mon_out;
	endproperty
	a_mon_in: assert property (p_mon_in) else $error("monitor high inside band"); // R11
endmodule
`default_nettype wire

// >>> rtl/acm_pkg.sv
/*
 package of the analog compare monitor: fixed-point formats, parameter ranges, reset values.
 assumes gain is given in hundredths (a value of 100 means a gain of 1.00).
*/
package acm_pkg;
	localparam int SAMPLE_W      = 16;
	localparam int GAIN_W        = 16;
	localparam int PARAM_W       = 16;
	localparam int PROD_W        = 34;
	localparam int SCALED_W      = 36;
	localparam int DIFF_W        = 38;
	localparam int DIGITS_W      = 2;
	localparam int GAIN_DIV      = 100;
	localparam logic signed [GAIN_W-1:0]  GAIN_MAX   = 16'sh03E8;
	localparam logic signed [PARAM_W-1:0] OFFSET_MAX = 16'sh2710;
	localparam logic signed [PARAM_W-1:0] THRESH_MAX = 16'sh4E20;
	localparam logic signed [SAMPLE_W-1:0] REF_RESET = 16'sh0000;
	localparam logic                      OUT_RESET  = 1'b0;
	typedef enum logic [1:0] {
		ACM_MODE_HYST   = 2'b01,
		ACM_MODE_WINDOW = 2'b10
	} acm_mode_type;
endpackage

// >>> rtl/acm_scale.sv
/*
 scaling stage: value * gain / 100 + offset, with gain and offset clamped to their ranges.
 assumes signed synchronous inputs; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_scale
	import acm_pkg::*;
(
	// operands
	input  wire logic signed [SAMPLE_W-1:0] i_value,
	input  wire logic signed [GAIN_W-1:0]   i_gain,
	input  wire logic signed [PARAM_W-1:0]  i_offset,
	// result
	output logic signed [SCALED_W-1:0]      o_scaled
);
	logic signed [GAIN_W-1:0]   gain_c;
	logic signed [PARAM_W-1:0]  offset_c;
	logic signed [PROD_W-1:0]   prod;
	always_comb begin
		gain_c = i_gain;
		if (i_gain > GAIN_MAX)
			gain_c = GAIN_MAX; // R2
		else if (i_gain < -GAIN_MAX)
			gain_c = -GAIN_MAX;
		offset_c = i_offset;
		if (i_offset > OFFSET_MAX)
			offset_c = OFFSET_MAX; // R2
		else if (i_offset < -OFFSET_MAX)
			offset_c = -OFFSET_MAX;
		prod = PROD_W'(i_value) * PROD_W'(gain_c);
		o_scaled = SCALED_W'(prod / PROD_W'(signed'(GAIN_DIV))) + SCALED_W'(offset_c); // R1 R9
	end
endmodule
`default_nettype wire

// >>> tb/acm_src.sv
/*
 upstream sample source: two converter samples for the comparator.
 assumes a random word from the bench that is stable around the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_src
	import acm_pkg::*;
(
	// clock and random word
	input  wire logic                  i_clk,
	input  wire logic [31:0]           i_rnd,
	// samples
	output logic signed [SAMPLE_W-1:0] o_first,
	output logic signed [SAMPLE_W-1:0] o_second
);
	initial begin
		o_first = '0;
		o_second = '0;
	end
	always @(negedge i_clk) begin
		o_first <= SAMPLE_W'(i_rnd[15:0] % 1001);
		o_second <= SAMPLE_W'(i_rnd[31:16] % 1001);
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 bench of the analog compare monitor: integer model compared every cycle.
 assumes the source model feeds the comparator samples.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import acm_pkg::*;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               en = 1'b0;
	logic signed [15:0] x, y, cg, co, con, coff, mi, mb, mref;
	logic [1:0]         cd, md;
	logic               cmp_out, mon_out;
	logic [31:0]        rnd = 32'h0000_42b6;
	int                 fails = 0, tests_run = 0, mc, mm, mr, pe, d, on_t, off_t, bw, ls, rs;
	int gt[4] = '{100, 100, 2500, -250};
	int ot[4] = '{0, 30, 30000, -400};
	int nt[4] = '{200, -100, 3000, -25000};
	int ft[4] = '{50, 300, -3000, 100};
	int bt[4] = '{100, 0, -50, 30000};
	always #12.5 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always @(posedge clk) rnd <= lfsr(rnd);
	acm_src src (.i_clk(clk), .i_rnd(rnd), .o_first(x), .o_second(y));
	acm_top dut (.i_clk(clk), .i_rst(rst), .i_first_analog_input(x), .i_second_analog_input(y),
		.i_cmp_gain(cg), .i_cmp_offset(co), .i_cmp_on(con), .i_cmp_off(coff), .i_cmp_digits(cd),
		.o_cmp_out(cmp_out), .i_mon_enable(en), .i_mon_input(mi), .i_mon_gain(cg),
		.i_mon_offset(co), .i_mon_band(mb), .i_mon_digits(md), .o_mon_out(mon_out),
		.o_mon_reference(mref));
	function automatic int cl(int v, int m);
		return v > m ? m : (v < -m ? -m : v);
	endfunction
	function automatic int sc(int v, int g, int b);
		return v * cl(g, 1000) / 100 + cl(b, 10000);
	endfunction
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mc = int'(OUT_RESET);
			mm = int'(OUT_RESET);
			mr = int'(REF_RESET);
			pe = 0;
		end else begin
			d = sc(x, cg, co) - sc(y, cg, co);
			on_t = cl(con, 20000);
			off_t = cl(coff, 20000);
			if (on_t >= off_t) begin
				if (d > on_t) mc = 1;
				else if (d < off_t) mc = 0;
			end else begin
				mc = (d >= on_t && d < off_t);
			end
			if (en && !pe) mr = mi;
			pe = en;
			bw = cl(mb < 0 ? -mb : mb, 20000);
			ls = sc(mi, cg, co);
			rs = sc(mr, cg, co);
			mm = en && (ls > rs + bw || ls < rs - bw);
		end
	end
	always @(negedge clk) begin
		if (!rst) begin
			chk("cmp_out", 16'(cmp_out), 16'(mc));
			chk("mon_out", 16'(mon_out), 16'(mm));
			chk("mon_ref", mref, 16'(mr));
		end
	end
	initial begin
		{cg, co, con, coff, mi, mb, cd, md} = '0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int p = 0; p < 4; p++) begin
			if (p == 2) begin
				rst = 1'b1;
				repeat (2) @(negedge clk);
				chk("rst_cmp", 16'(cmp_out), 16'(OUT_RESET));
				chk("rst_mon", 16'(mon_out), 16'(OUT_RESET));
				chk("rst_ref", mref, REF_RESET);
				rst = 1'b0;
			end
			cg = 16'(gt[p]);
			co = 16'(ot[p]);
			con = 16'(nt[p]);
			coff = 16'(ft[p]);
			mb = 16'(bt[p]);
			for (int i = 0; i < 400; i++) begin
				@(negedge clk);
				cd = rnd[1:0];
				md = rnd[3:2];
				mi = 16'(500 + int'(rnd[11:4]) - 128);
				if (rnd[15:12] == 4'h0) en = ~en;
			end
		end
		close_out();
	end
endmodule
`default_nettype wire
